// [prbs_check_map.svh]
// Register offsets, field positions and reset values of the lane checker.
// Assumes byte-wide registers placed one to a 32-bit APB word.
`ifndef PRBS_CHECK_MAP_SVH
`define PRBS_CHECK_MAP_SVH
`define IDX_SETUP_WORD     12'h314
`define IDX_ENABLE_MASK    12'h315
`define IDX_TEST_CONTROL   12'h316
`define IDX_LIMIT_LOW      12'h317
`define IDX_LIMIT_MID      12'h318
`define IDX_LIMIT_HIGH     12'h319
`define IDX_TALLY_LOW      12'h31a
`define IDX_TALLY_MID      12'h31b
`define IDX_TALLY_HIGH     12'h31c
`define IDX_PASS_FLAGS     12'h31d
`define IDX_IRQ_STATUS     12'h320
`define IDX_IRQ_MASK       12'h321
`define CTL_CLEAR_BIT      0
`define CTL_RUN_BIT        1
`define CTL_PAT_LSB        2
`define CTL_SEL_LSB        4
`define CTL_WRITE_MASK     8'h7f
`define PASS_RESET         8'hff
`define TALLY_MAX          24'hffffff
`define SEED_LAST          5'h1e
`endif

// [prbs_check_pkg.sv]
// Types shared by the lane checker.
// Assumes nothing beyond a SystemVerilog compiler.
package prbs_check_pkg;
    typedef enum logic [1:0] {
        PAT_PRBS7  = 2'b00,
        PAT_PRBS15 = 2'b01,
        PAT_PRBS31 = 2'b10
    } pattern_t;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_SEED = 2'b01,
        ST_RUN  = 2'b10
    } test_state_t;
endpackage

// [prbs_lane_checker.sv]
// Eight-lane PRBS bit error checker with its APB register file.
// Assumes lane bits arrive one per clk on lane_data, from outside the domain.
`timescale 1ns/1ps
`include "prbs_check_map.svh"

// Summary of operation
// - Bit x of the enable mask switches the error test on for lane x.
// - Control bits 6 to 4 choose which lane's tally shows in the tally bytes.
// - Control bits 3 to 2 choose PRBS7 (00), PRBS15 (01) or PRBS31 (10).
// - Control bit 1 runs the test while high and stops it while low.
// - Control bit 0 holds the test state machine and all tallies cleared.
// - The 24-bit error limit spans three byte registers, low byte first.
// - The selected lane's 24-bit tally reads from three bytes, low first.
// - Each lane's pass flag is 1 while its tally is zero or below the limit.
module prbs_lane_checker
    import prbs_check_pkg::*;
(
    input  wire logic        clk,       // 125 MHz clock
    input  wire logic        sys_rst,   // Asynchronous reset, active high
    input  wire logic        psel,      // APB select
    input  wire logic        penable,   // APB access phase
    input  wire logic        pwrite,    // APB write
    input  wire logic [13:0] paddr,     // APB byte address
    input  wire logic [31:0] pwdata,    // APB write data
    output logic      [31:0] prdata,    // APB read data
    output logic             pready,    // APB ready
    output logic             pslverr,   // APB error on unmapped address
    input  wire logic [7:0]  lane_data, // Deserialized bit, one per lane
    output logic             irq        // Level interrupt
);

    //------------------------------------------------------------------
    // Register file
    //------------------------------------------------------------------
    logic [7:0]  serial_phy_setup_word, next_serial_phy_setup_word;
    logic [7:0]  lane_test_enable_mask, next_lane_test_enable_mask;
    logic [7:0]  lane_test_control, next_lane_test_control;
    logic [23:0] error_limit, next_error_limit;
    logic [7:0]  irq_status, next_irq_status;
    logic [7:0]  irq_mask, next_irq_mask;
    logic [31:0] next_prdata;
    logic [7:0]  read_byte;
    logic        next_irq;
    logic        next_pslverr;

    logic [23:0] lane_error_tally [8];
    logic [23:0] next_tally [8];
    logic [7:0]  lane_pass_flags;
    logic [7:0]  pass_prev, next_pass_prev;
    logic [30:0] ref_lfsr [8];
    logic [30:0] next_lfsr [8];
    logic [7:0]  sync_a, sync_b;
    test_state_t state, next_state;
    logic [4:0]  seed_count, next_seed_count;

    logic [11:0] idx;
    logic        wr_en, rd_en, mapped;
    logic [2:0]  err_sel;
    pattern_t    pattern_select;
    logic        test_run, test_clear;
    logic [23:0] sel_tally;

    assign idx            = paddr[13:2];
    assign wr_en          = psel && penable && pwrite;
    assign rd_en          = psel && penable && !pwrite;
    assign pready         = 1'b1;
    assign test_clear     = lane_test_control[`CTL_CLEAR_BIT];
    assign test_run       = lane_test_control[`CTL_RUN_BIT];
    assign pattern_select = pattern_t'(lane_test_control[`CTL_PAT_LSB +: 2]);
    assign err_sel        = lane_test_control[`CTL_SEL_LSB +: 3];
    assign sel_tally      = lane_error_tally[err_sel];

    always_comb begin
        mapped = 1'b1;
        case (idx)
            `IDX_SETUP_WORD, `IDX_ENABLE_MASK, `IDX_TEST_CONTROL,
            `IDX_LIMIT_LOW, `IDX_LIMIT_MID, `IDX_LIMIT_HIGH,
            `IDX_TALLY_LOW, `IDX_TALLY_MID, `IDX_TALLY_HIGH,
            `IDX_PASS_FLAGS, `IDX_IRQ_STATUS, `IDX_IRQ_MASK: mapped = 1'b1;
            default: mapped = 1'b0;
        endcase
    end

    always_comb begin
        next_serial_phy_setup_word = serial_phy_setup_word;
        next_lane_test_enable_mask = lane_test_enable_mask;
        next_lane_test_control     = lane_test_control;
        next_error_limit           = error_limit;
        next_irq_mask              = irq_mask;
        next_prdata                = prdata;
        next_pslverr               = 1'b0;
        if (psel && !penable) begin
            next_pslverr = !mapped;
        end
        if (wr_en) begin
            case (idx)
                `IDX_SETUP_WORD:   next_serial_phy_setup_word = pwdata[7:0];
                `IDX_ENABLE_MASK:  next_lane_test_enable_mask = pwdata[7:0];
                `IDX_TEST_CONTROL: next_lane_test_control =
                                       pwdata[7:0] & `CTL_WRITE_MASK;
                `IDX_LIMIT_LOW: begin
                    next_error_limit[7:0] = pwdata[7:0];
                end
                `IDX_LIMIT_MID: begin
                    next_error_limit[15:8] = pwdata[7:0];
                end
                `IDX_LIMIT_HIGH: begin
                    next_error_limit[23:16] = pwdata[7:0];
                end
                `IDX_IRQ_MASK:     next_irq_mask = pwdata[7:0];
                default: ;
            endcase
        end
        if (psel && !penable && !pwrite) begin
            next_prdata = {24'h000000, read_byte};
        end
    end

    //------------------------------------------------------------------
    // Register read mux
    //------------------------------------------------------------------
    // Tally bytes are read live, so the three bytes of a running lane can
    // tear; stop the test first when a consistent value is needed.
    always_comb begin
        read_byte = 8'h00;
        case (idx)
            `IDX_SETUP_WORD:   read_byte = serial_phy_setup_word;
            `IDX_ENABLE_MASK:  read_byte = lane_test_enable_mask;
            `IDX_TEST_CONTROL: read_byte = lane_test_control;
            `IDX_LIMIT_LOW:    read_byte = error_limit[7:0];
            `IDX_LIMIT_MID:    read_byte = error_limit[15:8];
            `IDX_LIMIT_HIGH:   read_byte = error_limit[23:16];
            `IDX_TALLY_LOW:    read_byte = sel_tally[7:0];
            `IDX_TALLY_MID:    read_byte = sel_tally[15:8];
            `IDX_TALLY_HIGH:   read_byte = sel_tally[23:16];
            `IDX_PASS_FLAGS:   read_byte = lane_pass_flags;
            `IDX_IRQ_STATUS:   read_byte = irq_status;
            `IDX_IRQ_MASK:     read_byte = irq_mask;
            default:           read_byte = 8'h00;
        endcase
    end

    //------------------------------------------------------------------
    // Interrupt status
    //------------------------------------------------------------------
    // A lane that newly fails raises its status bit; the set beats the clear.
    always_comb begin
        next_pass_prev  = lane_pass_flags;
        next_irq_status = irq_status;
        if (wr_en && idx == `IDX_IRQ_STATUS) begin
            next_irq_status = irq_status & ~pwdata[7:0];
        end
        next_irq_status = next_irq_status | (pass_prev & ~lane_pass_flags);
        next_irq        = |(next_irq_status & next_irq_mask);
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            serial_phy_setup_word <= 8'h00;
            lane_test_enable_mask <= 8'h00;
            lane_test_control     <= 8'h00;
            error_limit           <= 24'h000000;
            irq_status            <= 8'h00;
            irq_mask              <= 8'h00;
            pass_prev             <= `PASS_RESET;
            prdata                <= 32'h0;
            pslverr               <= 1'b0;
            irq                   <= 1'b0;
        end else begin
            serial_phy_setup_word <= next_serial_phy_setup_word;
            lane_test_enable_mask <= next_lane_test_enable_mask;
            lane_test_control     <= next_lane_test_control;
            error_limit           <= next_error_limit;
            irq_status            <= next_irq_status;
            irq_mask              <= next_irq_mask;
            pass_prev             <= next_pass_prev;
            prdata                <= next_prdata;
            pslverr               <= next_pslverr;
            irq                   <= next_irq;
        end
    end

    //------------------------------------------------------------------
    // Lane input synchroniser
    //------------------------------------------------------------------
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            sync_a <= 8'h00;
            sync_b <= 8'h00;
        end else begin
            sync_a <= lane_data;
            sync_b <= sync_a;
        end
    end

    //------------------------------------------------------------------
    // Test state machine
    //------------------------------------------------------------------
    // Seeding loads each reference generator from the incoming bits so
    // the local copy locks to the far-end sequence before counting. The
    // seed lasts long enough to fill the longest generator, so no lane
    // counts errors while its reference is still locking in.
    always_comb begin
        next_state      = state;
        next_seed_count = seed_count;
        case (state)
            ST_IDLE: begin
                next_seed_count = 5'h00;
                if (test_run) begin
                    next_state = ST_SEED;
                end
            end
            ST_SEED: begin
                next_seed_count = seed_count + 5'h01;
                if (!test_run) begin
                    next_state = ST_IDLE;
                end else if (seed_count == `SEED_LAST) begin
                    next_state = ST_RUN;
                end
            end
            ST_RUN: begin
                if (!test_run) begin
                    next_state = ST_IDLE;
                end
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
        if (test_clear) begin
            next_state      = ST_IDLE;
            next_seed_count = 5'h00;
        end
    end

    function automatic logic ref_bit(input logic [30:0] r, input pattern_t p);
        case (p)
            PAT_PRBS7:  ref_bit = r[6] ^ r[5];
            PAT_PRBS15: ref_bit = r[14] ^ r[13];
            PAT_PRBS31: ref_bit = r[30] ^ r[27];
            default:    ref_bit = r[6] ^ r[5];
        endcase
    endfunction

    //------------------------------------------------------------------
    // Lane checkers
    //------------------------------------------------------------------
    // Once locked, every reference runs on its own prediction, so one bad
    // bit on the line counts once instead of echoing through the taps.
    always_comb begin
        logic expect_bit;
        expect_bit = 1'b0;
        for (int i = 0; i < 8; i++) begin
            next_lfsr[i]  = ref_lfsr[i];
            next_tally[i] = lane_error_tally[i];
            expect_bit    = ref_bit(ref_lfsr[i], pattern_select);
            if (state == ST_SEED || (state == ST_IDLE && test_run)) begin
                next_lfsr[i] = {ref_lfsr[i][29:0], sync_b[i]};
            end else if (state == ST_RUN) begin
                next_lfsr[i] = {ref_lfsr[i][29:0], expect_bit};
                if (lane_test_enable_mask[i]
                    && expect_bit != sync_b[i]
                    && lane_error_tally[i] != `TALLY_MAX) begin
                    next_tally[i] = lane_error_tally[i] + 24'h000001;
                end
            end
            if (test_clear) begin
                next_tally[i] = 24'h000000;
                next_lfsr[i]  = 31'h0;
            end
        end
    end

    // An error-free lane passes even when the limit is zero, so every
    // flag reads one after reset and while the test clear is held.
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            lane_pass_flags[i] = lane_error_tally[i] < error_limit
                || lane_error_tally[i] == 24'h000000;
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            state      <= ST_IDLE;
            seed_count <= 5'h00;
            for (int i = 0; i < 8; i++) begin
                lane_error_tally[i] <= 24'h000000;
                ref_lfsr[i]         <= 31'h0;
            end
        end else begin
            state      <= next_state;
            seed_count <= next_seed_count;
            for (int i = 0; i < 8; i++) begin
                lane_error_tally[i] <= next_tally[i];
                ref_lfsr[i]         <= next_lfsr[i];
            end
        end
    end

endmodule // prbs_lane_checker

// [prbs_lane_checker_assertions.sv]
// Concurrent checks on the APB port and interrupt of the lane checker.
// Assumes it is bound to every prbs_lane_checker and sees only its ports.
`timescale 1ns/1ps
`include "prbs_check_map.svh"
module prbs_lane_checker_assertions (
    input wire logic        clk,     // Clock
    input wire logic        sys_rst, // Reset, active high
    input wire logic        psel,    // APB select
    input wire logic        penable, // APB access phase
    input wire logic        pwrite,  // APB write
    input wire logic [13:0] paddr,   // APB byte address
    input wire logic [31:0] pwdata,  // APB write data
    input wire logic [31:0] prdata,  // APB read data
    input wire logic        pready,  // APB ready
    input wire logic        pslverr, // APB error
    input wire logic        irq      // Interrupt
);
    logic [11:0] idx;
    logic [7:0]  mir [6];
    logic [7:0]  imask;
    logic [2:0]  clr_age;
    logic        acc, rd, mapped, wr_rw;
    assign idx = paddr[13:2];
    assign acc = psel && penable && pready;
    assign rd = acc && !pwrite;
    assign wr_rw = idx >= `IDX_SETUP_WORD && idx <= `IDX_LIMIT_HIGH;
    assign mapped = (idx >= `IDX_SETUP_WORD && idx <= `IDX_PASS_FLAGS)
        || idx == `IDX_IRQ_STATUS || idx == `IDX_IRQ_MASK;
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    // Shadow copies of what software wrote, and the age of the clear bit.
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            mir <= '{default: 8'h0};
            imask <= 8'h0;
            clr_age <= 3'h0;
        end else begin
            if (acc && pwrite && wr_rw) begin
                mir[3'(idx - `IDX_SETUP_WORD)] <= pwdata[7:0];
            end
            if (acc && pwrite && idx == `IDX_IRQ_MASK) begin
                imask <= pwdata[7:0];
            end
            clr_age <= !mir[2][0] ? 3'h0 : clr_age + 3'(clr_age != 3'h7);
        end
    end
    a_unmapped_err: assert property (acc && !mapped |-> pslverr)
        else $error("unmapped access without error");
    a_mapped_clean: assert property (acc && mapped |-> !pslverr)
        else $error("mapped access flagged as error");
    a_read_upper: assert property (rd |-> prdata[31:8] == 24'h0)
        else $error("read data upper bits not zero");
    a_reg_readback: assert property (rd && wr_rw |-> prdata[7:0] ==
        (idx == `IDX_TEST_CONTROL ? mir[2] & 8'h7f
        : mir[3'(idx - `IDX_SETUP_WORD)]))
        else $error("register read back differs from write");
    a_tally_cleared: assert property (rd && idx >= `IDX_TALLY_LOW
        && idx <= `IDX_TALLY_HIGH && clr_age >= 3'h2 |-> prdata[7:0] == 8'h0)
        else $error("tally not zero while clear held");
    a_pass_on_clear: assert property (rd && idx == `IDX_PASS_FLAGS
        && clr_age >= 3'h2 |-> prdata[7:0] == 8'hff)
        else $error("pass flag low while tallies are cleared");
    a_irq_masked: assert property (imask == 8'h0 |-> !irq)
        else $error("interrupt raised while fully masked");
    a_prdata_held: assert property (!(psel && !penable && !pwrite)
        |=> $stable(prdata))
        else $error("read data changed outside read setup");
endmodule // prbs_lane_checker_assertions
bind prbs_lane_checker prbs_lane_checker_assertions u_chk (.clk, .sys_rst,
    .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .irq);

// [prbs_lane_tx.sv]
// Serial transmitter model: one PRBS bit per lane per clock.
// Assumes the bench drives pattern and a one-cycle lane flip mask.
`timescale 1ns/1ps
module prbs_lane_tx (
    input  wire logic       clk,     // Clock
    input  wire logic       sys_rst, // Reset, active high
    input  wire logic [1:0] pattern, // Sequence select
    input  wire logic [7:0] flip,    // Lanes to corrupt now
    output logic      [7:0] lane_out // One bit per lane
);
    logic [30:0] sr;
    logic        nb;
    assign nb = pattern == 2'h0 ? sr[6] ^ sr[5]
              : pattern == 2'h1 ? sr[14] ^ sr[13] : sr[30] ^ sr[27];
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            sr <= 31'h1;
            lane_out <= 8'h0;
        end else begin
            sr <= {sr[29:0], nb};
            lane_out <= {8{nb}} ^ flip;
        end
    end
endmodule // prbs_lane_tx

// [tb_serdes_prbs_lane_checker.sv]
// Self-checking bench for the eight-lane PRBS checker.
// Assumes the checker, its map header and the lane source model.
`timescale 1ns/1ps
`include "prbs_check_map.svh"
module tb_serdes_prbs_lane_checker;
    logic        clk = 0, sys_rst = 1, psel = 0, penable = 0, pwrite = 0;
    logic [13:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, rd;
    logic        pready, pslverr, irq, err;
    logic [7:0]  lane_data, en, f, flip = '0;
    logic [1:0]  pattern = '0;
    logic [23:0] tally [8] = '{default: 24'h0};
    logic [23:0] lim = '0;
    integer      seed = 32'he488;
    int          fail_count = 0, cmp_count = 0;
    always #4 clk = ~clk;
    prbs_lane_checker u_dut (.clk, .sys_rst, .psel, .penable, .pwrite,
        .paddr, .pwdata, .prdata, .pready, .pslverr, .lane_data, .irq);
    prbs_lane_tx u_tx (.clk, .sys_rst, .pattern, .flip, .lane_out(lane_data));
    task automatic chk(string name, logic [31:0] exp, logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
            fail_count++;
        end
    endtask
    task automatic apb(logic wr, logic [11:0] idx, logic [31:0] wd);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= {idx, 2'b00};
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask
    function automatic logic [7:0] pass_exp();
        for (int x = 0; x < 8; x++)
            pass_exp[x] = tally[x] < lim || tally[x] == 24'h0;
    endfunction
    task automatic conclude();
        $display("Comparisons %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    initial begin
        repeat (10) @(posedge clk);
        sys_rst <= 1'b0;
        @(posedge clk);
        apb(0, `IDX_PASS_FLAGS, '0);
        chk("pass at reset", 32'(pass_exp()), rd);
        for (int a = 'h314; a <= 'h31c; a++) begin
            apb(0, 12'(a), '0);
            chk("reset value", '0, rd);
            f = 8'($random(seed));
            if (a == 'h316) f[0] = 1'b1;
            apb(1, 12'(a), {24'h0, f});
            apb(0, 12'(a), '0);
            chk("read back", 32'(a > 'h319 ? 8'h0 : a == 'h316 ? f & 8'h7f
                : f), rd);
        end
        apb(0, 12'h31e, '0);
        chk("unmapped error", 1, 32'(err));
        apb(1, `IDX_SETUP_WORD, 32'h1);
        for (int p = 0; p < 3; p++) begin
            pattern <= 2'(p);
            lim = 24'(1 + ($random(seed) & 3));
            en = 8'($random(seed));
            apb(1, `IDX_LIMIT_LOW, {8'h0, lim});
            apb(1, `IDX_LIMIT_MID, '0);
            apb(1, `IDX_LIMIT_HIGH, '0);
            apb(1, `IDX_ENABLE_MASK, {24'h0, en});
            apb(1, `IDX_TEST_CONTROL, 32'(p * 4 + 2));
            repeat (80) @(posedge clk);
            apb(1, `IDX_TEST_CONTROL, 32'(p * 4 + 3));
            apb(1, `IDX_TEST_CONTROL, 32'(p * 4 + 2));
            repeat (40) @(posedge clk);
            apb(1, `IDX_IRQ_STATUS, 32'hff);
            apb(1, `IDX_IRQ_MASK, 32'hff);
            for (int x = 0; x < 8; x++) tally[x] = '0;
            repeat (6) begin
                f = 8'($random(seed));
                flip <= f;
                @(posedge clk);
                flip <= '0;
                for (int x = 0; x < 8; x++) tally[x] += 24'(en[x] & f[x]);
                repeat (40) @(posedge clk);
            end
            apb(1, `IDX_TEST_CONTROL, 32'(p * 4));
            flip <= 8'hff;
            @(posedge clk);
            flip <= '0;
            repeat (40) @(posedge clk);
            chk("irq", 32'(|(en & ~pass_exp())), 32'(irq));
            apb(0, `IDX_IRQ_STATUS, '0);
            chk("irq status", 32'(en & ~pass_exp()), rd);
            apb(1, `IDX_IRQ_STATUS, 32'hff);
            chk("irq cleared", 0, 32'(irq));
            for (int x = 0; x < 8; x++) begin
                apb(1, `IDX_TEST_CONTROL, 32'(x * 16 + p * 4));
                apb(0, `IDX_TALLY_LOW, '0);
                chk("tally low", 32'(tally[x][7:0]), rd);
                apb(0, `IDX_TALLY_MID, '0);
                chk("tally mid", 32'(tally[x][15:8]), rd);
                apb(0, `IDX_TALLY_HIGH, '0);
                chk("tally high", 32'(tally[x][23:16]), rd);
            end
            apb(0, `IDX_PASS_FLAGS, '0);
            chk("pass flags", 32'(pass_exp()), rd);
            apb(1, `IDX_TEST_CONTROL, 32'h71);
            apb(0, `IDX_TALLY_LOW, '0);
            chk("tally cleared", 0, rd);
            apb(0, `IDX_PASS_FLAGS, '0);
            chk("pass while cleared", 32'hff, rd);
        end
        conclude();
    end
    initial begin
        #200000;
        fail_count++;
        conclude();
    end
endmodule // tb_serdes_prbs_lane_checker
